/* design/conv_ctl.sv */
// conv_ctl: control, status, compare and result registers of a 10-bit converter
// assumes APB master, converter core via conv_if, trigger input asynchronous
//
// Contract
// [RULE1] control-one write aborts, restarts unless channel off (code restarts only with software trigger; hardware trigger arms)
// [RULE2] compare off: flag set every completion (code: not set for a completion while the 10-bit result is locked)
// [RULE3] compare on: flag set only if true
// [RULE4] flag cleared by control-one write, lower-result read
// [RULE5] interrupt when flag set and enabled
// [RULE6] continuous off: one conversion per trigger
// [RULE7] hardware continuous starts on trigger event
// [RULE8] channel codes: inputs, reserved, references
// [RULE9] channel all ones: converter off, no extra
// [RULE10] single mode idles after completion
// [RULE11] active bit set on start, cleared end/abort
// [RULE12] trigger select: software write or hardware
// [RULE13] bit five enables compare function
// [RULE14] bit four: less-than or greater-equal sense
// [RULE15] software writes zeros to reserved bits
// [RULE16] upper result reads zero in 8-bit
// [RULE17] results kept when compare fails
// [RULE18] 10-bit upper read locks until lower read
// [RULE19] 8-bit mode has no read interlock
// [RULE20] mode change invalidates upper result
// [RULE21] lower result holds low eight bits
// [RULE22] mode 00 is 8-bit, 10 is 10-bit
// [RULE23] 8-bit compare ignores upper compare bits
// [RULE24] hardware trigger synchronised, edge detected
// [RULE25] flag set wins over same-cycle clear
`timescale 1ns/1ps
module conv_ctl
	import conv_ctl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        hardware_trigger_in,
	output logic [4:0]       channel_select,
	output logic             ref_high_sel,
	output logic             ref_low_sel,
	output logic             completion_irq,
	conv_if.ctl              core
);
	import conv_ctl_pkg::*;

	//------------------------------------------------------------
	// bus decode
	//------------------------------------------------------------
	logic       wr;
	logic       rd;
	logic       mapped;
	logic       wr_one;
	logic       rd_upper;
	logic       rd_lower;

	assign pready  = 1'b1;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;
	assign mapped  = paddr inside {OFF_CTL_ONE, OFF_CTL_TWO, OFF_RES_UPPER, OFF_RES_LOWER,
	                               OFF_CMP_UPPER, OFF_CMP_LOWER, OFF_CONFIG};
	assign pslverr = psel & penable & ~mapped;
	assign wr_one   = wr & (paddr == OFF_CTL_ONE);
	assign rd_upper = rd & (paddr == OFF_RES_UPPER);
	assign rd_lower = rd & (paddr == OFF_RES_LOWER);

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	logic       flag;
	logic       irq_en;
	logic       cont;
	logic       active;
	logic       trig_sel;
	logic       cmp_en;
	logic       cmp_ge;
	logic [1:0] cmp_upper;
	logic [7:0] cmp_lower;
	logic [7:0] config_reg;
	logic [1:0] res_upper;
	logic [7:0] res_lower;
	logic       locked;
	logic       armed;
	logic       hw_rise;
	logic [1:0] mode;

	assign mode = config_reg[CFG_MODE_LO +: 2];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_en         <= 1'b0;
			cont           <= 1'b0;
			channel_select <= RST_CTL_ONE[4:0];
		end else if (wr_one) begin
			irq_en         <= pwdata[BIT_IRQ_EN];
			cont           <= pwdata[BIT_CONT];
			channel_select <= pwdata[4:0];
		end
	end

	// reserved bits 3:0 are not stored; software keeps them zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			trig_sel   <= 1'b0;
			cmp_en     <= 1'b0;
			cmp_ge     <= 1'b0;
			cmp_upper  <= 2'h0;
			cmp_lower  <= RST_ZERO;
			config_reg <= RST_ZERO;
		end else if (wr) begin
			if (paddr == OFF_CTL_TWO) begin
				trig_sel <= pwdata[BIT_TRIG_SEL]; // [RULE12]
				cmp_en   <= pwdata[BIT_CMP_EN];   // [RULE13] [RULE15]
				cmp_ge   <= pwdata[BIT_CMP_GE];   // [RULE14]
			end
			if (paddr == OFF_CMP_UPPER)
				cmp_upper <= pwdata[1:0];
			if (paddr == OFF_CMP_LOWER)
				cmp_lower <= pwdata[7:0];
			if (paddr == OFF_CONFIG)
				config_reg <= pwdata[7:0];
		end
	end

	//------------------------------------------------------------
	// channel decode
	//------------------------------------------------------------
	logic chan_off;
	assign chan_off     = (channel_select == CH_OFF);     // [RULE9]
	assign ref_high_sel = (channel_select == CH_REF_HIGH); // [RULE8]
	assign ref_low_sel  = (channel_select == CH_REF_LOW);  // [RULE8]
	assign core.powered = ~chan_off & (active | cont);     // [RULE9] [RULE10]

	//------------------------------------------------------------
	// trigger and sequencing
	//------------------------------------------------------------
	trig_edge u_trig (
		.clk        (clk),
		.reset_n    (reset_n),
		.level_in   (hardware_trigger_in),
		.rise_pulse (hw_rise)
	);

	logic sw_start;
	logic hw_start;
	logic rerun;
	assign sw_start  = wr_one & (pwdata[4:0] != CH_OFF);                 // [RULE1]
	// write restarts only in software mode; hardware mode arms instead
	// a trigger edge that meets a control write is dropped: the write wins
	assign hw_start  = trig_sel & hw_rise & armed & ~chan_off & ~active & ~wr_one; // [RULE7]
	assign rerun     = core.done & cont & ~chan_off & ~wr_one;          // [RULE6]
	assign core.abort = wr_one & active;                                 // [RULE1]
	assign core.start = (sw_start & ~trig_sel) | hw_start | rerun;     // [RULE1] [RULE12]

	// armed: hardware mode waits for one trigger per write in single mode
	always_ff @(posedge clk) begin
		if (!reset_n)
			armed <= 1'b0;
		else if (wr_one)
			armed <= (pwdata[4:0] != CH_OFF);
		else if (hw_start & ~cont)
			armed <= 1'b0; // [RULE6]
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			active <= 1'b0;
		else if (core.start)
			active <= 1'b1; // [RULE11]
		else if (core.done | core.abort)
			active <= 1'b0; // [RULE11] [RULE10]
	end

	//------------------------------------------------------------
	// compare and result transfer
	//------------------------------------------------------------
	function automatic logic cmp_true(input logic [9:0] r, input logic [1:0] m,
	                                  input logic [1:0] cu, input logic [7:0] cl,
	                                  input logic ge);
		logic [9:0] a;
		logic [9:0] b;
		a = (m == MODE_10BIT) ? r : {2'h0, r[7:0]};
		b = (m == MODE_10BIT) ? {cu, cl} : {2'h0, cl}; // [RULE23]
		return ge ? (a >= b) : (a < b);                // [RULE14]
	endfunction

	logic hit;
	logic take;
	logic is10;
	assign is10 = (mode == MODE_10BIT);                                    // [RULE22]
	assign hit  = ~cmp_en | cmp_true(core.result, mode, cmp_upper, cmp_lower, cmp_ge); // [RULE2] [RULE3]
	assign take = core.done & active & hit & ~(locked & is10);             // [RULE17] [RULE18]

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			res_upper <= 2'h0;
			res_lower <= RST_ZERO;
		end else if (wr & (paddr == OFF_CONFIG) & (pwdata[CFG_MODE_LO +: 2] != mode)) begin
			res_upper <= 2'h0; // [RULE20]
		end else if (take) begin
			res_upper <= is10 ? core.result[9:8] : 2'h0; // [RULE16]
			res_lower <= core.result[7:0]; // [RULE21]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			locked <= 1'b0;
		else if (rd_lower | ~is10)
			locked <= 1'b0; // [RULE19]
		else if (rd_upper)
			locked <= 1'b1; // [RULE18]
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			flag <= 1'b0;
		else if (take)
			flag <= 1'b1; // [RULE25] [RULE2]
		else if (wr_one | rd_lower)
			flag <= 1'b0; // [RULE4]
	end

	assign completion_irq = flag & irq_en; // [RULE5]

	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	// latched at setup, so side effects of the access never show in it
	always_ff @(posedge clk) begin
		if (!reset_n)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite) begin
			unique case (paddr)
				OFF_CTL_ONE:   prdata <= {24'h0, flag, irq_en, cont, channel_select};
				OFF_CTL_TWO:   prdata <= {24'h0, active, trig_sel, cmp_en, cmp_ge, 4'h0};
				OFF_RES_UPPER: prdata <= {30'h0, is10 ? res_upper : 2'h0}; // [RULE16]
				OFF_RES_LOWER: prdata <= {24'h0, res_lower};
				OFF_CMP_UPPER: prdata <= {30'h0, cmp_upper};
				OFF_CMP_LOWER: prdata <= {24'h0, cmp_lower};
				OFF_CONFIG:    prdata <= {24'h0, config_reg};
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	a_flag_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
		(wr_one | rd_lower) & ~take |=> ~flag) else $error("flag not cleared");
	a_flag_set: assert property (@(posedge clk) disable iff (!reset_n) // [RULE25]
		take |=> flag) else $error("flag not set on completion");
	a_irq_gate: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
		completion_irq |-> flag && irq_en) else $error("irq without flag");
	a_active_set: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
		core.start |=> active) else $error("active not set");
	a_active_end: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
		core.abort & ~core.start |=> ~active) else $error("active not cleared");
	a_off_nostart: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
		wr_one & (pwdata[4:0] == CH_OFF) |-> ~core.start) else $error("start on off code");
	a_cmp_keep: assert property (@(posedge clk) disable iff (!reset_n) // [RULE17]
		core.done & ~hit |=> $stable(res_lower)) else $error("result changed");
	a_lock_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
		locked & is10 & ~rd_lower |=> $stable(res_lower) || $past(rd_lower))
		else $error("locked result changed");
	a_upper_zero: assert property (@(posedge clk) disable iff (!reset_n) // [RULE16]
		take & ~is10 |=> res_upper == 2'h0) else $error("upper bits nonzero");
	a_single_idle: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
		core.done & ~cont & ~core.start |=> ~active) else $error("no idle");

	c_sw_conv: cover property (@(posedge clk) disable iff (!reset_n) wr_one ##[1:40] take);
	c_hw_conv: cover property (@(posedge clk) disable iff (!reset_n) hw_start ##[1:40] take);
	c_lock_drop: cover property (@(posedge clk) disable iff (!reset_n) locked & is10 & core.done);
	c_irq: cover property (@(posedge clk) disable iff (!reset_n) $rose(completion_irq));
	c_cont_rerun: cover property (@(posedge clk) disable iff (!reset_n) rerun);

	//------------------------------------------------------------
	// sequencing and result checks
	//------------------------------------------------------------
	a_sw_restart: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
		wr_one & ~trig_sel & (pwdata[4:0] != CH_OFF) |-> core.start)
		else $error("no restart on write");
	a_abort_idle: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
		wr_one & active & (pwdata[4:0] == CH_OFF) |=> ~active)
		else $error("abort left conversion active");
	a_hw_source: assert property (@(posedge clk) disable iff (!reset_n) // [RULE12]
		trig_sel & ~hw_rise & ~core.done |-> ~core.start)
		else $error("start without trigger edge");
	a_sw_source: assert property (@(posedge clk) disable iff (!reset_n) // [RULE12]
		~trig_sel & ~wr_one & ~core.done |-> ~core.start)
		else $error("start without control write");
	a_hw_cont_arm: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
		hw_start & cont |=> armed)
		else $error("continuous trigger disarmed");
	a_hw_single: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
		hw_start & ~cont |=> ~armed)
		else $error("single trigger still armed");
	a_cont_rerun: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
		core.done & active & cont & ~chan_off & ~wr_one |=> active)
		else $error("continuous sequence stopped");
	a_single_once: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
		core.done & ~cont & ~wr_one & ~hw_start |-> ~core.start)
		else $error("extra single conversion");
	a_off_quiet: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
		chan_off & ~wr_one |-> ~core.start)
		else $error("start while converter off");
	a_idle_power: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
		core.done & ~cont & ~core.start & ~wr_one |=> ~core.powered)
		else $error("converter left powered");
	a_reserved_code: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
		channel_select == CH_RESERVED |-> ~ref_high_sel & ~ref_low_sel)
		else $error("reserved code selects reference");
	a_ref_excl: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
		1'b1 |-> !(ref_high_sel && ref_low_sel))
		else $error("both references selected");
	a_cmp_noflag: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
		core.done & ~hit & ~flag |=> ~flag)
		else $error("flag set on failed compare");
	a_flag_plain: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
		core.done & active & ~cmp_en & ~(locked & is10) |=> flag)
		else $error("flag missed without compare");
	a_irq_raise: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
		take & irq_en & ~wr_one |=> completion_irq)
		else $error("interrupt not raised");
	a_flag_hold: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
		flag & ~wr_one & ~rd_lower |=> flag)
		else $error("flag lost without clear");
	a_lock_set: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
		rd_upper & is10 |=> locked)
		else $error("upper read did not lock");
	a_lock_drop: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
		core.done & locked & is10 & ~wr |=> $stable(res_upper))
		else $error("locked upper result changed");
	a_no_lock8: assert property (@(posedge clk) disable iff (!reset_n) // [RULE19]
		~is10 |=> ~locked)
		else $error("lock in 8-bit mode");
	a_mode_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RULE20]
		wr & (paddr == OFF_CONFIG) & (pwdata[CFG_MODE_LO +: 2] != mode) |=> res_upper == 2'h0)
		else $error("upper result kept over mode change");
	a_cmp_upper: assert property (@(posedge clk) disable iff (!reset_n) // [RULE17]
		core.done & ~hit & ~wr |=> $stable(res_upper))
		else $error("upper result changed on failed compare");
endmodule

/* design/conv_ctl_pkg.sv */
// conv_ctl_pkg: register map, field positions and reset values of the converter control block
// assumes a 32-bit APB slave with one register per aligned word
package conv_ctl_pkg;
	localparam logic [11:0] OFF_CTL_ONE    = 12'h000;
	localparam logic [11:0] OFF_CTL_TWO    = 12'h004;
	localparam logic [11:0] OFF_RES_UPPER  = 12'h008;
	localparam logic [11:0] OFF_RES_LOWER  = 12'h00C;
	localparam logic [11:0] OFF_CMP_UPPER  = 12'h010;
	localparam logic [11:0] OFF_CMP_LOWER  = 12'h014;
	localparam logic [11:0] OFF_CONFIG     = 12'h018;

	localparam int BIT_FLAG       = 7;
	localparam int BIT_IRQ_EN     = 6;
	localparam int BIT_CONT       = 5;
	localparam int BIT_ACTIVE     = 7;
	localparam int BIT_TRIG_SEL   = 6;
	localparam int BIT_CMP_EN     = 5;
	localparam int BIT_CMP_GE     = 4;
	localparam int CFG_MODE_LO    = 2;

	localparam logic [4:0] CH_RESERVED = 5'h1C;
	localparam logic [4:0] CH_REF_HIGH = 5'h1D;
	localparam logic [4:0] CH_REF_LOW  = 5'h1E;
	localparam logic [4:0] CH_OFF      = 5'h1F;

	localparam logic [1:0] MODE_8BIT  = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;

	localparam logic [7:0] RST_CTL_ONE = 8'h1F;
	localparam logic [7:0] RST_ZERO    = 8'h00;
endpackage

/* design/conv_if.sv */
// conv_if: start/abort and completion handshake toward the converter core
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface conv_if;
	logic       start;
	logic       abort;
	logic       done;
	logic [9:0] result;
	logic       powered;
	modport ctl (output start, output abort, output powered, input done, input result);
	modport core (input start, input abort, input powered, output done, output result);
endinterface

/* design/trig_edge.sv */
// trig_edge: two-flop synchroniser and rising-edge pulse for the hardware trigger
// assumes trigger level stays high for at least two clocks
`timescale 1ns/1ps
module trig_edge (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic level_in,
	output logic      rise_pulse
);
	logic sync_a;
	logic sync_b;
	logic sync_c;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else begin
			sync_a <= level_in;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	// first flop feeds only the second
	assign rise_pulse = sync_b & ~sync_c; // [RULE24]
endmodule

/* tb/conv_core_model.sv */
// conv_core_model: behavioural converter core, answers start with a done pulse
// assumes start and abort pulses from conv_ctl on the shared clock
`timescale 1ns/1ps
module conv_core_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [7:0] lat,
	input  wire logic [9:0] value,
	conv_if.core            core
);
	logic       busy;
	logic [7:0] cnt;
	logic [9:0] last;

	// result valid only with done; scrambled otherwise so stale captures show
	assign core.result = core.done ? last : ~last;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			last <= 10'h000;
			core.done <= 1'b0;
		end else begin
			core.done <= 1'b0;
			if (core.start) begin
				busy <= 1'b1;
				cnt <= lat;
			end else if (core.abort) begin
				busy <= 1'b0;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'b0;
				core.done <= 1'b1;
				last <= value;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

/* tb/test_adc_control_result_registers.sv */
// test_adc_control_result_registers: apb sequences against conv_ctl
// assumes conv_core_model stands in for the converter core
`timescale 1ns/1ps
module test_adc_control_result_registers;
	import conv_ctl_pkg::*;
	logic        clk;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        trig = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, q;
	logic        pready, pslverr, perr, irq, rh, rl;
	logic [4:0]  channel;
	logic [7:0]  lat = 8'h04;
	logic [9:0]  value = 10'h000;
	logic [4:0]  codes [3] = '{5'h03, CH_REF_HIGH, CH_REF_LOW};
	int          err_total = 0;
	int          tests_run = 0;
	int          dones = 0;
	int          starts = 0;
	int          aborts = 0;
	int          d, s;

	conv_if cif ();
	conv_ctl u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hardware_trigger_in(trig),
		.channel_select(channel), .ref_high_sel(rh), .ref_low_sel(rl),
		.completion_irq(irq), .core(cif));
	conv_core_model u_core (.clk(clk), .reset_n(reset_n), .lat(lat), .value(value),
		.core(cif));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		dones += (cif.done === 1'b1);
		starts += (cif.start === 1'b1);
		aborts += (cif.abort === 1'b1);
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] dat);
		apb(1'b1, a, dat);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	// bounded wait; a lost completion counts as a mismatch
	task automatic wait_done(input int n);
		int k;
		k = 0;
		while (dones < n && k < 400) begin
			@(posedge clk);
			k++;
		end
		if (dones < n)
			err_total++;
		repeat (2) @(posedge clk);
	endtask

	task automatic hw_pulse;
		trig <= 1'b1;
		repeat (6) @(posedge clk);
		trig <= 1'b0;
		repeat (20) @(posedge clk);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		complete_run;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(OFF_CTL_ONE, {24'h0, RST_CTL_ONE});
		rd(OFF_CTL_TWO, 32'h0);
		rd(12'h01C, 32'h0);
		check(perr, 1'b1);
		check(channel, CH_OFF);
		$display("test reset done");
		wr(OFF_CONFIG, 32'h08);
		value <= 10'h2A5;
		d = dones;
		wr(OFF_CTL_ONE, 32'h45);
		wait_done(d + 1);
		check(irq, 1'b1);
		rd(OFF_CTL_ONE, 32'hC5);
		rd(OFF_CTL_TWO, 32'h0);
		repeat (20) @(posedge clk);
		check(dones, d + 1);
		rd(OFF_RES_UPPER, 32'h2);
		value <= 10'h155;
		wr(OFF_CTL_ONE, 32'h05);
		wait_done(d + 2);
		rd(OFF_RES_UPPER, 32'h2);
		rd(OFF_RES_LOWER, 32'hA5);
		rd(OFF_CTL_ONE, 32'h05);
		$display("test single done");
		wr(OFF_CMP_UPPER, 32'h1);
		wr(OFF_CMP_LOWER, 32'h0);
		wr(OFF_CTL_TWO, 32'h20);
		value <= 10'h1F0;
		wr(OFF_CTL_ONE, 32'h05);
		wait_done(d + 3);
		rd(OFF_CTL_ONE, 32'h05);
		rd(OFF_RES_LOWER, 32'hA5);
		wr(OFF_CTL_TWO, 32'h30);
		wr(OFF_CTL_ONE, 32'h05);
		wait_done(d + 4);
		check(irq, 1'b0);
		rd(OFF_CTL_ONE, 32'h85);
		rd(OFF_RES_UPPER, 32'h1);
		rd(OFF_RES_LOWER, 32'hF0);
		wr(OFF_CONFIG, 32'h0);
		rd(OFF_RES_UPPER, 32'h0);
		wr(OFF_CTL_TWO, 32'h0);
		value <= 10'h3FF;
		wr(OFF_CTL_ONE, 32'h05);
		wait_done(d + 5);
		rd(OFF_RES_UPPER, 32'h0);
		value <= 10'h2C3;
		wr(OFF_CTL_TWO, 32'h30);
		wr(OFF_CTL_ONE, 32'h05);
		wait_done(d + 6);
		rd(OFF_CTL_ONE, 32'h85);
		rd(OFF_RES_LOWER, 32'hC3);
		wr(OFF_CTL_TWO, 32'h0);
		$display("test compare done");
		d = dones;
		wr(OFF_CTL_ONE, 32'h25);
		repeat (40) @(posedge clk);
		check(dones - d > 2, 1'b1);
		wr(OFF_CTL_ONE, 32'h1F);
		d = dones;
		repeat (30) @(posedge clk);
		check(dones, d);
		check(cif.powered, 1'b0);
		rd(OFF_CTL_TWO, 32'h0);
		foreach (codes[i]) begin
			wr(OFF_CTL_ONE, {27'h0, codes[i]});
			check({channel, rh, rl}, {codes[i], codes[i] == CH_REF_HIGH,
				codes[i] == CH_REF_LOW});
			repeat (12) @(posedge clk);
		end
		$display("test continuous done");
		lat <= 8'h3C;
		d = dones;
		wr(OFF_CTL_ONE, 32'h05);
		rd(OFF_CTL_TWO, 32'h80);
		s = aborts;
		wr(OFF_CTL_ONE, 32'h05);
		check(aborts > s, 1'b1);
		wait_done(d + 1);
		repeat (70) @(posedge clk);
		check(dones, d + 1);
		$display("test abort done");
		lat <= 8'h04;
		wr(OFF_CTL_TWO, 32'h40);
		s = starts;
		wr(OFF_CTL_ONE, 32'h05);
		repeat (10) @(posedge clk);
		check(starts, s);
		hw_pulse;
		check(starts, s + 1);
		wr(OFF_CTL_ONE, 32'h25);
		repeat (10) @(posedge clk);
		check(starts, s + 1);
		hw_pulse;
		repeat (20) @(posedge clk);
		check(starts - s > 3, 1'b1);
		wr(OFF_CTL_ONE, 32'h1F);
		$display("test hardware trigger done");
		complete_run;
	end
endmodule
